/* core/uicf_ctrl.sv */
// Interrupt mask, prioritised interrupt cause, line status and queue control of one UART channel
// Function
// RL1: FIFO receive interrupt follows trigger level
// RL2: Data ready set on push, clear empty
// RL3: Polled mode: mask zero, status via line
// RL4: Line status bit layout reported
// RL5: Mask bit 0 enables receive interrupt
// RL6: Mask bit 1 enables transmit empty interrupt
// RL7: Overrun immediate, tag errors at head
// RL8: Mask bit 3 enables modem change interrupt
// RL9: Timeout four chars plus twelve bits
// RL10: Line/modem interrupts cleared by their reads
// RL11: Transmit interrupt cleared by cause read/write
// RL12: Cause code encodes highest pending source
// RL13: Held cause kept until serviced
// RL14: Cause bit 0 low when pending
// RL15: Cause bits 7:6 show FIFO enable
// RL16: Queue bits ignored unless enable bit set
// RL17: Receive queue reset self-clearing pulse
// RL18: Transmit queue reset self-clearing pulse
// RL19: Queue bit 3 selects DMA mode
// RL20: Trigger level 1, 4, 8, 14
// RL21: Reserved bits read zero
// RL22: Mask selected only when divisor bit clear
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ns
`include "uicf_defs.svh"
module uicf_ctrl
  import uicf_pkg::*;
(
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_divisor_access,
  input  wire uicf_rx_t   i_rx,
  input  wire uicf_tx_t   i_tx,
  input  wire logic [3:0] i_modem_delta,
  input  wire logic       i_bit_tick,
  input  wire logic [3:0] i_char_bits,
  output logic [7:0]      o_rdata,
  output logic            o_irq,
  output logic            o_fifo_en,
  output logic            o_dma_mode,
  output logic [4:0]      o_rx_trigger,
  output logic            o_rx_fifo_rst,
  output logic            o_tx_fifo_rst,
  output logic            o_rx_data_ready
);

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic wr_mask, wr_queue, wr_data, rd_data, rd_cause, rd_line, rd_modem;
  assign wr_mask  = i_wr && i_addr == `UICF_A_MASK && !i_divisor_access; // see RL22
  assign wr_queue = i_wr && i_addr == `UICF_A_CAUSE && !i_divisor_access;
  assign wr_data  = i_wr && i_addr == `UICF_A_DATA && !i_divisor_access;
  assign rd_data  = i_rd && i_addr == `UICF_A_DATA && !i_divisor_access;
  assign rd_cause = i_rd && i_addr == `UICF_A_CAUSE && !i_divisor_access;
  assign rd_line  = i_rd && i_addr == `UICF_A_LINE;
  assign rd_modem = i_rd && i_addr == `UICF_A_MODEM;

  // ----------------------------------------
  // Interrupt mask
  // ----------------------------------------
  logic [3:0] mask_r;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      mask_r <= 4'h0; // see RL5
    end else if (wr_mask) begin
      mask_r <= i_wdata[3:0]; // see RL21
    end
  end

  // ----------------------------------------
  // Queue control
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_fifo_en    <= 1'b0;
      o_dma_mode   <= 1'b0; // see RL19
      o_rx_trigger <= `UICF_TRIG_1;
    end else if (wr_queue) begin
      o_fifo_en <= i_wdata[`UICF_QC_EN];
      if (i_wdata[`UICF_QC_EN]) begin // see RL16
        o_dma_mode <= i_wdata[`UICF_QC_DMA]; // see RL19
        case (i_wdata[`UICF_QC_TRIG]) // see RL20
          2'h0:    o_rx_trigger <= `UICF_TRIG_1;
          2'h1:    o_rx_trigger <= `UICF_TRIG_4;
          2'h2:    o_rx_trigger <= `UICF_TRIG_8;
          default: o_rx_trigger <= `UICF_TRIG_14;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rx_fifo_rst <= 1'b0;
      o_tx_fifo_rst <= 1'b0;
    end else begin
      o_rx_fifo_rst <= wr_queue && i_wdata[`UICF_QC_EN] && i_wdata[`UICF_QC_RXRST]; // see RL17
      o_tx_fifo_rst <= wr_queue && i_wdata[`UICF_QC_EN] && i_wdata[`UICF_QC_TXRST]; // see RL18
    end
  end

  // ----------------------------------------
  // Line status flags
  // ----------------------------------------
  logic overrun_r;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rx_data_ready <= 1'b0;
      overrun_r       <= 1'b0;
    end else begin
      if (i_rx.push) begin
        o_rx_data_ready <= 1'b1; // see RL2
      end else if (i_rx.level == 5'h00) begin
        o_rx_data_ready <= 1'b0; // see RL2
      end
      if (i_rx.overrun) begin
        overrun_r <= 1'b1;
      end else if (rd_line) begin
        overrun_r <= 1'b0;
      end
    end
  end

  logic [7:0] line_val;
  assign line_val = {i_rx.err_any, i_tx.tx_idle, i_tx.tx_empty, i_rx.head_err, overrun_r, o_rx_data_ready}; // see RL4

  // ----------------------------------------
  // Interrupt sources
  // ----------------------------------------
  logic head_err_d_r, ls_pend_r, tx_empty_d_r, tx_pend_r, ms_ack_r, to_pend_r;
  logic [6:0] to_cnt_r;
  logic [6:0] to_limit;
  logic       rx_hit, ms_hit;
  uicf_cause_t cause_r;
  assign to_limit = {3'h0, i_char_bits} * `UICF_TO_CHARS + `UICF_TO_BITS; // see RL9
  assign rx_hit = o_fifo_en ? (i_rx.level >= o_rx_trigger) : (i_rx.level != 5'h00); // see RL1
  assign ms_hit = |i_modem_delta && !ms_ack_r; // see RL8

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      head_err_d_r <= 1'b0;
      ls_pend_r    <= 1'b0;
    end else begin
      head_err_d_r <= |i_rx.head_err;
      if (i_rx.overrun || (|i_rx.head_err && !head_err_d_r)) begin
        ls_pend_r <= 1'b1; // see RL7
      end else if (rd_line) begin
        ls_pend_r <= 1'b0; // see RL10
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_empty_d_r <= 1'b0;
      tx_pend_r    <= 1'b0;
    end else begin
      tx_empty_d_r <= i_tx.tx_empty;
      if (i_tx.tx_empty && !tx_empty_d_r) begin
        tx_pend_r <= 1'b1; // see RL6
      end else if (wr_data || (rd_cause && cause_r == UICF_TX)) begin
        tx_pend_r <= 1'b0; // see RL11
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ms_ack_r <= 1'b0;
    end else if (rd_modem) begin
      ms_ack_r <= 1'b1; // see RL10
    end else if (i_modem_delta == 4'h0) begin
      ms_ack_r <= 1'b0;
    end
  end

  // Timeout restarts on every push or data read and only runs with data waiting
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      to_cnt_r  <= 7'h00;
      to_pend_r <= 1'b0;
    end else begin
      if (i_rx.push || rd_data || !o_fifo_en || i_rx.level == 5'h00) begin
        to_cnt_r <= 7'h00;
      end else if (i_bit_tick && to_cnt_r != to_limit) begin
        to_cnt_r <= to_cnt_r + 7'h01;
      end
      if (rd_data || !o_fifo_en) begin
        to_pend_r <= 1'b0; // see RL9
      end else if (i_bit_tick && to_cnt_r + 7'h01 == to_limit && i_rx.level != 5'h00 && !i_rx.push) begin
        to_pend_r <= 1'b1; // see RL9
      end
    end
  end

  // ----------------------------------------
  // Cause selection
  // ----------------------------------------
  logic p_ls, p_to, p_rx, p_tx, p_ms, held_live;
  uicf_cause_t top_cause;
  assign p_ls = ls_pend_r && mask_r[`UICF_M_LS];
  assign p_to = to_pend_r && mask_r[`UICF_M_RX];
  assign p_rx = rx_hit && mask_r[`UICF_M_RX]; // see RL5
  assign p_tx = tx_pend_r && mask_r[`UICF_M_TX]; // see RL6
  assign p_ms = ms_hit && mask_r[`UICF_M_MS]; // see RL8

  always_comb begin
    if (p_ls) begin
      top_cause = UICF_LS; // see RL12
    end else if (p_to) begin
      top_cause = UICF_TO;
    end else if (p_rx) begin
      top_cause = UICF_RX;
    end else if (p_tx) begin
      top_cause = UICF_TX;
    end else if (p_ms) begin
      top_cause = UICF_MS;
    end else begin
      top_cause = UICF_NONE;
    end
  end

  always_comb begin
    case (cause_r)
      UICF_LS: held_live = p_ls;
      UICF_TO: held_live = p_to;
      UICF_RX: held_live = p_rx;
      UICF_TX: held_live = p_tx;
      UICF_MS: held_live = p_ms;
      default: held_live = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cause_r <= UICF_NONE;
      o_irq   <= 1'b0;
    end else begin
      if (!held_live) begin
        cause_r <= top_cause; // see RL13
      end
      o_irq <= held_live || top_cause != UICF_NONE; // see RL3
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (rd_cause) begin
      o_rdata <= {{2{o_fifo_en}}, 2'b00, cause_r}; // see RL14 see RL15 see RL21
    end else if (i_rd && i_addr == `UICF_A_MASK && !i_divisor_access) begin
      o_rdata <= {4'h0, mask_r}; // see RL21
    end else if (rd_line) begin
      o_rdata <= line_val; // see RL4
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_rx_level;
    o_fifo_en && mask_r[`UICF_M_RX] && i_rx.level >= o_rx_trigger && !p_ls && !p_to |=> cause_r != UICF_NONE;
  endproperty
  a_rx_level: assert property (p_rx_level) else $error("receive level not reported"); // see RL1

  property p_ready;
    i_rx.push |=> o_rx_data_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("data ready not set"); // see RL2

  property p_polled;
    (mask_r == 4'h0) [*2] |=> !o_irq;
  endproperty
  a_polled: assert property (p_polled) else $error("interrupt with mask clear"); // see RL3

  property p_line_read;
    rd_line |=> o_rdata[5] == $past(i_tx.tx_empty) && o_rdata[6] == $past(i_tx.tx_idle);
  endproperty
  a_line_read: assert property (p_line_read) else $error("line status bits wrong"); // see RL4

  property p_ovr;
    i_rx.overrun |=> ls_pend_r && overrun_r;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not pending"); // see RL7

  property p_tx_clear;
    wr_data && !(i_tx.tx_empty && !tx_empty_d_r) |=> !tx_pend_r;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("transmit interrupt not cleared"); // see RL11

  property p_no_pend;
    rd_cause && cause_r == UICF_NONE |=> o_rdata[0];
  endproperty
  a_no_pend: assert property (p_no_pend) else $error("none pending bit low"); // see RL14

  property p_fifo_bits;
    rd_cause |=> o_rdata[7:6] == {2{$past(o_fifo_en)}} && o_rdata[5:4] == 2'b00;
  endproperty
  a_fifo_bits: assert property (p_fifo_bits) else $error("cause upper bits wrong"); // see RL15

  property p_ignore;
    wr_queue && !i_wdata[`UICF_QC_EN] |=> $stable(o_dma_mode) && !o_rx_fifo_rst && !o_tx_fifo_rst;
  endproperty
  a_ignore: assert property (p_ignore) else $error("queue bits taken without enable"); // see RL16

  property p_rst_pulse;
    o_rx_fifo_rst && !(wr_queue && i_wdata[`UICF_QC_RXRST]) |=> !o_rx_fifo_rst;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("receive reset not self clearing"); // see RL17

  property p_mask_guard;
    i_wr && i_addr == `UICF_A_MASK && i_divisor_access |=> $stable(mask_r);
  endproperty
  a_mask_guard: assert property (p_mask_guard) else $error("mask written under divisor access"); // see RL22

  property p_to_clear;
    rd_data |=> !to_pend_r;
  endproperty
  a_to_clear: assert property (p_to_clear) else $error("timeout not cleared by data read"); // see RL9

  property p_ls_clear;
    rd_line && !i_rx.overrun && !(|i_rx.head_err && !head_err_d_r) |=> !ls_pend_r;
  endproperty
  a_ls_clear: assert property (p_ls_clear) else $error("line interrupt not cleared by read"); // see RL10

  property p_ms_clear;
    rd_modem |=> !p_ms;
  endproperty
  a_ms_clear: assert property (p_ms_clear) else $error("modem interrupt not cleared by read"); // see RL10

  property p_ls_first;
    p_ls && !held_live |=> cause_r == UICF_LS;
  endproperty
  a_ls_first: assert property (p_ls_first) else $error("line status not top priority"); // see RL12

  property p_hold;
    held_live |=> $stable(cause_r);
  endproperty
  a_hold: assert property (p_hold) else $error("held cause replaced while pending"); // see RL13

  property p_pend_low;
    rd_cause && cause_r != UICF_NONE |=> !o_rdata[0];
  endproperty
  a_pend_low: assert property (p_pend_low) else $error("pending bit high with cause held"); // see RL14

  property p_tx_set;
    i_tx.tx_empty && !tx_empty_d_r |=> tx_pend_r;
  endproperty
  a_tx_set: assert property (p_tx_set) else $error("transmit empty not pending"); // see RL6

  property p_ready_clr;
    !i_rx.push && i_rx.level == 5'h00 |=> !o_rx_data_ready;
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("data ready kept with queue empty"); // see RL2

  property p_trig_max;
    wr_queue && i_wdata[`UICF_QC_EN] && i_wdata[`UICF_QC_TRIG] == 2'h3 |=> o_rx_trigger == `UICF_TRIG_14;
  endproperty
  a_trig_max: assert property (p_trig_max) else $error("top trigger level not taken"); // see RL20

  property p_tx_pulse;
    o_tx_fifo_rst && !(wr_queue && i_wdata[`UICF_QC_TXRST]) |=> !o_tx_fifo_rst;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("transmit reset not self clearing"); // see RL18

endmodule // uicf_ctrl

/* core/uicf_defs.svh */
// Register offsets, field positions, codes and timing counts of the interrupt and queue control block
`ifndef UICF_DEFS_SVH
`define UICF_DEFS_SVH
`define UICF_A_DATA    3'h0
`define UICF_A_MASK    3'h1
`define UICF_A_CAUSE   3'h2
`define UICF_A_LINE    3'h5
`define UICF_A_MODEM   3'h6
`define UICF_QC_EN     0
`define UICF_QC_RXRST  1
`define UICF_QC_TXRST  2
`define UICF_QC_DMA    3
`define UICF_QC_TRIG   7:6
`define UICF_M_RX      0
`define UICF_M_TX      1
`define UICF_M_LS      2
`define UICF_M_MS      3
`define UICF_C_LS      4'h6
`define UICF_C_TO      4'hc
`define UICF_C_RX      4'h4
`define UICF_C_TX      4'h2
`define UICF_C_MS      4'h0
`define UICF_C_NONE    4'h1
`define UICF_TRIG_1    5'h01
`define UICF_TRIG_4    5'h04
`define UICF_TRIG_8    5'h08
`define UICF_TRIG_14   5'h0e
`define UICF_TO_CHARS  7'h04
`define UICF_TO_BITS   7'h0c
`endif

/* core/uicf_pkg.sv */
// Types shared by the interrupt and queue control block
package uicf_pkg;
`include "uicf_defs.svh"
  typedef enum logic [3:0] {
    UICF_LS   = `UICF_C_LS,
    UICF_TO   = `UICF_C_TO,
    UICF_RX   = `UICF_C_RX,
    UICF_TX   = `UICF_C_TX,
    UICF_MS   = `UICF_C_MS,
    UICF_NONE = `UICF_C_NONE
  } uicf_cause_t;
  typedef struct packed {
    logic [4:0] level;
    logic       push;
    logic       overrun;
    logic [2:0] head_err;
    logic       err_any;
  } uicf_rx_t;
  typedef struct packed {
    logic tx_empty;
    logic tx_idle;
  } uicf_tx_t;
endpackage

/* sim/uicf_host.sv */
// Host processor model that drives the register port of the interrupt and queue control block
`timescale 1ns/1ns
module uicf_host (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rdata,
  output logic      [2:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial begin
    o_addr = 3'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One-cycle write; the value is driven as given, and queue control bit 0 is not forced set
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    o_addr  <= a;
    o_wdata <= v;
    o_wr    <= 1'b1;
    @(posedge i_clk_sys);
    o_wr    <= 1'b0;
  endtask

  // One-cycle read; data taken in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk_sys);
    o_rd   <= 1'b0;
    @(negedge i_clk_sys);
    v = i_rdata;
  endtask
endmodule  // uicf_host

/* sim/tb_uicf_ctrl.sv */
// Self-checking bench for the interrupt and queue control block
`timescale 1ns/1ns
module tb_uicf_ctrl;
  import uicf_pkg::*;
  logic       i_clk_sys = 1'b0;
  logic       i_rst     = 1'b1;
  logic       div       = 1'b0;
  logic       tick      = 1'b0;
  logic [3:0] delta     = 4'h0;
  logic [3:0] cbits     = 4'ha;
  uicf_rx_t   rx        = '0;
  uicf_tx_t   tx        = '0;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d;
  logic       wr, rd, irq, fen, dma, rxr, txr, dr;
  logic [4:0] trig;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         m_mask;
  int         trig_tab[4] = '{1, 4, 8, 14};

  always #25 i_clk_sys = ~i_clk_sys;

  uicf_host uicf_host_inst (.i_clk_sys(i_clk_sys), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr),
    .o_rd(rd));
  uicf_ctrl uicf_ctrl_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .i_divisor_access(div), .i_rx(rx), .i_tx(tx), .i_modem_delta(delta), .i_bit_tick(tick),
    .i_char_bits(cbits), .o_rdata(rdata), .o_irq(irq), .o_fifo_en(fen), .o_dma_mode(dma), .o_rx_trigger(trig),
    .o_rx_fifo_rst(rxr), .o_tx_fifo_rst(txr), .o_rx_data_ready(dr));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    uicf_host_inst.rd(a, d);
    chk(d, exp);
  endtask

  task automatic settle;
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask

  task automatic test_done;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      test_done;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h8fa226ff));
    repeat (16) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    rdc(3'h2, 8'h01);
    rdc(3'h1, 8'h00);
    chk({3'h0, trig}, 8'h01);
    repeat (4) begin
      m_mask = $urandom & 8'hff;
      uicf_host_inst.wr(3'h1, m_mask[7:0]);
      rdc(3'h1, m_mask[7:0] & 8'h0f);
    end
    @(posedge i_clk_sys);
    div <= 1'b1;
    uicf_host_inst.wr(3'h1, m_mask[7:0] ^ 8'h0f);
    div <= 1'b0;
    rdc(3'h1, m_mask[7:0] & 8'h0f);
    for (int k = 0; k < 4; k++) begin
      uicf_host_inst.wr(3'h2, {k[1:0], 2'b11, k[0], 3'b111});
      @(negedge i_clk_sys);
      chk({4'h0, rxr, txr, fen, dma}, {7'h07, k[0]});
      chk({3'h0, trig}, trig_tab[k][7:0]);
      @(negedge i_clk_sys);
      chk({6'h0, rxr, txr}, 8'h00);
      rdc(3'h2, 8'hc1);
    end
    uicf_host_inst.wr(3'h2, 8'h0e);
    @(negedge i_clk_sys);
    chk({4'h0, rxr, txr, fen, dma}, 8'h01);
    chk({3'h0, trig}, 8'h0e);
    rdc(3'h2, 8'h01);
    uicf_host_inst.wr(3'h2, 8'h41);
    uicf_host_inst.wr(3'h1, 8'h0f);
    @(posedge i_clk_sys);
    tx.tx_empty <= 1'b1;
    settle;
    chk({7'h0, irq}, 8'h01);
    @(posedge i_clk_sys);
    rx.overrun <= 1'b1;
    @(posedge i_clk_sys);
    rx.overrun <= 1'b0;
    settle;
    rdc(3'h2, 8'hc2);
    settle;
    rdc(3'h2, 8'hc6);
    rdc(3'h5, 8'h22);
    settle;
    rdc(3'h2, 8'hc1);
    @(posedge i_clk_sys);
    rx.level <= 5'h03;
    rx.push <= 1'b1;
    @(posedge i_clk_sys);
    rx.push <= 1'b0;
    settle;
    chk({6'h0, irq, dr}, 8'h01);
    @(posedge i_clk_sys);
    rx.level <= 5'h04;
    settle;
    rdc(3'h2, 8'hc4);
    @(posedge i_clk_sys);
    rx.level <= 5'h03;
    rx.head_err <= 3'b101;
    rx.err_any <= 1'b1;
    tx.tx_idle <= 1'b1;
    settle;
    rdc(3'h2, 8'hc6);
    rdc(3'h5, 8'hf5);
    settle;
    rdc(3'h2, 8'hc1);
    @(posedge i_clk_sys);
    rx.head_err <= 3'b000;
    rx.err_any <= 1'b0;
    rx.level <= 5'h01;
    rx.push <= 1'b1;
    @(posedge i_clk_sys);
    rx.push <= 1'b0;
    tick <= 1'b1;
    repeat (48) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk({7'h0, irq}, 8'h00);
    repeat (8) @(posedge i_clk_sys);
    tick <= 1'b0;
    settle;
    rdc(3'h2, 8'hcc);
    rdc(3'h0, 8'h00);
    settle;
    rdc(3'h2, 8'hc1);
    @(posedge i_clk_sys);
    delta <= 4'h4;
    settle;
    rdc(3'h2, 8'hc0);
    rdc(3'h6, 8'h00);
    settle;
    chk({7'h0, irq}, 8'h00);
    @(posedge i_clk_sys);
    delta <= 4'h0;
    tx.tx_empty <= 1'b0;
    uicf_host_inst.wr(3'h1, 8'h02);
    tx.tx_empty <= 1'b1;
    settle;
    chk({7'h0, irq}, 8'h01);
    uicf_host_inst.wr(3'h0, 8'h55);
    settle;
    chk({7'h0, irq}, 8'h00);
    uicf_host_inst.wr(3'h1, 8'h00);
    rx.level <= 5'h05;
    settle;
    chk({7'h0, irq}, 8'h00);
    rdc(3'h5, 8'h61);
    uicf_host_inst.wr(3'h2, 8'h00);
    uicf_host_inst.wr(3'h1, 8'h01);
    settle;
    rdc(3'h2, 8'h04);
    @(posedge i_clk_sys);
    rx.level <= 5'h00;
    settle;
    chk({6'h0, irq, dr}, 8'h00);
    test_done;
  end
endmodule  // tb_uicf_ctrl
